// ==== dv/rscl_board.sv ====
`timescale 1ns/100ps
`default_nettype none
module rscl_board #(
    parameter integer EXT_MIN_CYC = 30
) (
    // Clock and bench commands
    input wire logic        mclk,
    input wire logic [10:0] strap_val,
    input wire logic        ext_req,
    // Device pins
    input wire logic [10:0] gpio_out,
    input wire logic [10:0] gpio_oe_n,
    input wire logic        reset_line_oe_n,
    output logic     [10:0] gpio_in,
    output logic            reset_line_in
);
    integer hold_cnt = 0;
    logic   ext_low  = 1'h0;
    // External source holds the line low for its minimum span
    always @(posedge mclk) begin
        if (ext_req) begin
            ext_low <= 1'h1;
            hold_cnt <= EXT_MIN_CYC;
        end else if (hold_cnt > 1) begin
            hold_cnt <= hold_cnt - 1;
        end else begin
            ext_low <= 1'h0;
            hold_cnt <= 0;
        end
    end
    // Open-drain line with pull-up
    assign reset_line_in = !(ext_low || !reset_line_oe_n);
    // Strap resistors, overdriven by the device's own drivers
    assign gpio_in = (gpio_out & ~gpio_oe_n) | (strap_val & gpio_oe_n);
endmodule
`default_nettype wire

// ==== dv/rscl_top_properties.sv ====
`timescale 1ns/100ps
`default_nettype none
module rscl_props #(
    parameter integer RST_DELAY_CYC = 20
) (
    // Clock and reset
    input wire logic        mclk,
    input wire logic        rstn,
    // Pins
    input wire logic        power_good,
    input wire logic        reset_line_in,
    input wire logic        reset_line_oe_n,
    input wire logic [10:0] gpio_oe_n,
    // Decoded outputs
    input wire logic        sys_rstn,
    input wire logic        host_role_mac,
    input wire logic        host_link_type_select,
    input wire logic        full_duplex,
    input wire logic        autoneg_en,
    input wire logic        host_if_hiz,
    input wire logic [1:0]  speed_sel,
    input wire logic [4:0]  mgmt_addr,
    input wire logic        boot_from_flash,
    input wire logic        strap_fault,
    input wire logic        zc_tick
);
    // ----------------------------------------
    // Cycles since power-good came up
    // ----------------------------------------
    logic [31:0] pg_cnt;
    always @(posedge mclk or negedge rstn) begin
        if (!rstn)
            pg_cnt <= 32'h0000_0000;
        else if (!power_good)
            pg_cnt <= 32'h0000_0000;
        else if (pg_cnt != 32'hffff_ffff)
            pg_cnt <= pg_cnt + 32'h0000_0001;
    end
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!rstn);
    sequence held_low;
        !sys_rstn ##1 !sys_rstn;
    endsequence
    // ----------------------------------------
    // Properties
    // ----------------------------------------
    duplex_forced_a: assert property (!host_link_type_select |-> full_duplex)
        else $error("gigabit link not full duplex");
    isolate_phy_a: assert property (host_if_hiz |-> !host_role_mac)
        else $error("isolation outside PHY role");
    mgmt_low_a: assert property (mgmt_addr[2:0] == 3'h0)
        else $error("management address low bits set");
    boot_flash_a: assert property (boot_from_flash)
        else $error("boot source not flash");
    straps_frozen_a: assert property (sys_rstn && $past(sys_rstn, 2) |->
        $stable({host_role_mac, host_link_type_select, full_duplex, autoneg_en, host_if_hiz,
                 speed_sel, mgmt_addr, strap_fault}))
        else $error("decoded straps changed after reset");
    pins_released_a: assert property (!sys_rstn && !$past(sys_rstn) |-> &gpio_oe_n)
        else $error("pin driven during reset");
    reset_delay_a: assert property ($rose(sys_rstn) |-> pg_cnt >= RST_DELAY_CYC)
        else $error("reset released too early");
    line_hold_a: assert property (!reset_line_oe_n |-> held_low)
        else $error("reset released while line pulled");
    line_wait_a: assert property ($rose(sys_rstn) |->
        $past(reset_line_in) && $past(reset_line_in, 2))
        else $error("reset released while line low");
    zc_pulse_a: assert property (zc_tick |-> ##1 !zc_tick)
        else $error("zero-cross tick too long");
endmodule
`default_nettype wire

// ==== dv/testbench.sv ====
`timescale 1ns/100ps
`default_nettype none
module testbench;
    localparam integer RST_DELAY_CYC = 20;
    logic        mclk = 0, rstn = 0, psel = 0, penable = 0, pwrite = 0, ce = 1;
    logic        power_good = 0, zero_cross_in = 0, ext_req = 0, err;
    logic [7:0]  paddr = 8'h00;
    logic [31:0] pwdata = 32'h0000_0000, rd, phase_rd;
    logic [10:0] strap_val = 11'h3b7;
    logic [10:0] straps [0:4] = '{11'h3b7, 11'h38a, 11'h74c, 11'h677, 11'h1b7};
    wire  [31:0] prdata;
    wire  [10:0] gpio_in, gpio_out, gpio_oe_n;
    wire  [4:0]  mgmt_addr;
    wire  [1:0]  speed_sel;
    wire         pready, pslverr, reset_line_in, reset_line_out, reset_line_oe_n, sys_rstn;
    wire         host_role_mac, host_link_type_select, full_duplex, autoneg_en, host_if_hiz;
    wire         boot_from_flash, strap_fault, zc_tick;
    wire  [14:0] cfg_now = {strap_fault, boot_from_flash, mgmt_addr, &speed_sel, speed_sel,
                            host_if_hiz, autoneg_en, full_duplex, host_link_type_select,
                            host_role_mac};
    integer      bad_count = 0, total_checks = 0, zc_seen = 0, i;
    always #20 mclk = ~mclk;
    always @(posedge mclk) if (zc_tick === 1'h1) zc_seen <= zc_seen + 1;
    rscl_top #(.RST_DELAY_CYC(RST_DELAY_CYC)) dut (
        .mclk(mclk), .rstn(rstn), .ce(ce), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .power_good(power_good), .reset_line_in(reset_line_in), .reset_line_out(reset_line_out),
        .reset_line_oe_n(reset_line_oe_n), .gpio_in(gpio_in), .gpio_out(gpio_out),
        .gpio_oe_n(gpio_oe_n), .zero_cross_in(zero_cross_in), .sys_rstn(sys_rstn),
        .host_role_mac(host_role_mac), .host_link_type_select(host_link_type_select),
        .full_duplex(full_duplex), .autoneg_en(autoneg_en), .host_if_hiz(host_if_hiz),
        .speed_sel(speed_sel), .mgmt_addr(mgmt_addr), .boot_from_flash(boot_from_flash),
        .strap_fault(strap_fault), .zc_tick(zc_tick));
    rscl_board #(.EXT_MIN_CYC(30)) board (
        .mclk(mclk), .strap_val(strap_val), .ext_req(ext_req), .gpio_out(gpio_out),
        .gpio_oe_n(gpio_oe_n), .reset_line_oe_n(reset_line_oe_n), .gpio_in(gpio_in),
        .reset_line_in(reset_line_in));
    task chk(input logic [31:0] got, input logic [31:0] exp, input string what);
        total_checks = total_checks + 1;
        if (got !== exp) begin
            bad_count = bad_count + 1;
            $display("CHECK FAILED at %0t: %s got %h expected %h", $time, what, got, exp);
        end
    endtask
    task apb(input logic wr, input logic [7:0] a, input logic [31:0] wd);
        integer n;
        @(posedge mclk);
        psel <= 1; penable <= 0; pwrite <= wr; paddr <= a; pwdata <= wd;
        @(posedge mclk);
        penable <= 1;
        n = 0;
        do begin
            @(posedge mclk);
            n = n + 1;
        end while (pready !== 1'h1 && n < 20);
        rd = prdata;
        err = pslverr;
        chk(n < 20, 1, "bus answer");
        psel <= 0; penable <= 0;
    endtask
    function logic [14:0] exp_cfg(input logic [10:0] s);
        exp_cfg = {~s[8] | ~s[9], 1'h1, s[6], s[5], 3'h0, s[10] & s[4], s[10], s[4],
                   s[3] & ~s[7], s[2], s[0] | ~s[1], s[1], s[7]};
    endfunction
    task boot(input logic [10:0] s, input logic ext);
        integer n;
        @(posedge mclk);
        rstn <= 0; power_good <= 0; strap_val <= s;
        repeat (3) @(posedge mclk);
        rstn <= 1;
        repeat (2) @(posedge mclk);
        power_good <= 1; ext_req <= ext;
        @(posedge mclk);
        ext_req <= 0;
        n = 1;
        while (sys_rstn !== 1'h1 && n < 400) begin
            @(posedge mclk);
            n = n + 1;
        end
        chk(sys_rstn, 1, "reset released");
        chk(n >= (ext ? 30 : RST_DELAY_CYC), 1, "release delay");
        chk(reset_line_oe_n, 1, "reset line released");
        chk(reset_line_out, 0, "reset line drive level");
        chk(cfg_now, exp_cfg(s), "decoded straps");
    endtask
    task end_of_test;
        $display("Checks %0d mismatches %0d", total_checks, bad_count);
        if (bad_count == 0 && total_checks > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask
    initial begin
        #(40 * 20000);
        bad_count = bad_count + 1;
        $display("CHECK FAILED at %0t: watchdog expired", $time);
        end_of_test;
    end
    initial begin
        repeat (12) @(posedge mclk);
        for (i = 0; i < 5; i = i + 1) begin
            boot(straps[i], i == 1);
            apb(0, 8'h04, 32'h0000_0000);
            chk(rd, exp_cfg(straps[i]), "config word");
            apb(1, 8'h0c, 32'h0000_07ff);
            apb(1, 8'h08, {21'h00_0000, ~straps[i]});
            repeat (6) @(posedge mclk);
            chk(gpio_oe_n, 0, "led enable");
            chk(gpio_out, {21'h00_0000, ~straps[i]}, "led drive");
            chk(cfg_now, exp_cfg(straps[i]), "straps held");
            apb(0, 8'h08, 32'h0000_0000);
            chk(rd, {21'h00_0000, ~straps[i]}, "led register");
            apb(0, 8'h0c, 32'h0000_0000);
            chk(rd, 32'h0000_07ff, "led enable register");
            apb(0, 8'h00, 32'h0000_0000);
            chk(rd, straps[i], "captured straps");
            apb(0, 8'h10, 32'h0000_0000);
            chk(rd[10:0], {21'h00_0000, ~straps[i]}, "pin levels");
            chk(rd[16], 0, "reset flag");
            $display("Strap case %0d done", i);
        end
        apb(0, 8'h40, 32'h0000_0000);
        chk(err, 1, "unmapped error");
        chk(rd, 0, "unmapped data");
        apb(1, 8'h00, 32'h0000_0000);
        apb(0, 8'h00, 32'h0000_0000);
        chk(rd, straps[4], "read-only strap word");
        $display("Bus refusal test done");
        repeat (2) begin
            zero_cross_in <= 1;
            repeat (3) @(posedge mclk);
            zero_cross_in <= 0;
            repeat (47) @(posedge mclk);
        end
        chk(zc_seen, 2, "zero-cross ticks");
        apb(0, 8'h14, 32'h0000_0000);
        chk(rd >= 49 && rd <= 51, 1, "line period");
        apb(0, 8'h18, 32'h0000_0000);
        phase_rd = rd;
        ce <= 0;
        repeat (10) @(posedge mclk);
        ce <= 1;
        apb(0, 8'h18, 32'h0000_0000);
        chk(rd - phase_rd, 3, "phase count frozen by clock enable");
        $display("Zero-cross test done");
        end_of_test;
    end
endmodule
bind rscl_top rscl_props #(.RST_DELAY_CYC(RST_DELAY_CYC)) u_props (
    .mclk(mclk), .rstn(rstn), .power_good(power_good), .reset_line_in(reset_line_in),
    .reset_line_oe_n(reset_line_oe_n), .gpio_oe_n(gpio_oe_n), .sys_rstn(sys_rstn),
    .host_role_mac(host_role_mac), .host_link_type_select(host_link_type_select),
    .full_duplex(full_duplex), .autoneg_en(autoneg_en), .host_if_hiz(host_if_hiz),
    .speed_sel(speed_sel), .mgmt_addr(mgmt_addr), .boot_from_flash(boot_from_flash),
    .strap_fault(strap_fault), .zc_tick(zc_tick));
`default_nettype wire

// ==== src/rscl_map.vh ====
`ifndef RSCL_MAP_VH
`define RSCL_MAP_VH

// ----------------------------------------------------------------
// Clock and timing
// ----------------------------------------------------------------
`define RSCL_CLK_HZ          25000000
`define RSCL_RST_DELAY_MS    215
`define RSCL_RST_DELAY_CYC   (`RSCL_RST_DELAY_MS * (`RSCL_CLK_HZ / 1000))
`define RSCL_EXT_RST_MIN_MS  100

// ----------------------------------------------------------------
// Strap pin positions
// ----------------------------------------------------------------
`define RSCL_NUM_STRAPS      11
`define RSCL_S_DUPLEX        0
`define RSCL_S_LINK_TYPE     1
`define RSCL_S_AUTONEG       2
`define RSCL_S_ISOLATE       3
`define RSCL_S_SPEED0        4
`define RSCL_S_MGMT3         5
`define RSCL_S_MGMT4         6
`define RSCL_S_ROLE          7
`define RSCL_S_MEM_TYPE      8
`define RSCL_S_BOOT_SRC      9
`define RSCL_S_SPEED1        10
`define RSCL_STRAP_RESET     11'h3b7

// ----------------------------------------------------------------
// Speed codes
// ----------------------------------------------------------------
`define RSCL_SPEED_10        2'h0
`define RSCL_SPEED_100       2'h1
`define RSCL_SPEED_1000      2'h2
`define RSCL_SPEED_RSVD      2'h3

// ----------------------------------------------------------------
// Register offsets
// ----------------------------------------------------------------
`define RSCL_ADDR_W          8
`define RSCL_OFS_STRAP       8'h00
`define RSCL_OFS_CONFIG      8'h04
`define RSCL_OFS_LED_OUT     8'h08
`define RSCL_OFS_LED_EN      8'h0c
`define RSCL_OFS_STATUS      8'h10
`define RSCL_OFS_ZC_PERIOD   8'h14
`define RSCL_OFS_ZC_PHASE    8'h18

// ----------------------------------------------------------------
// Config register fields
// ----------------------------------------------------------------
`define RSCL_C_ROLE_MAC      0
`define RSCL_C_LINK_MII      1
`define RSCL_C_FULL_DUPLEX   2
`define RSCL_C_AUTONEG       3
`define RSCL_C_HOST_HIZ      4
`define RSCL_C_SPEED_LO      5
`define RSCL_C_SPEED_HI      6
`define RSCL_C_SPEED_RSVD    7
`define RSCL_C_MGMT_LO       8
`define RSCL_C_MGMT_HI       12
`define RSCL_C_BOOT_FLASH    13
`define RSCL_C_STRAP_FAULT   14

`endif

// ==== src/rscl_top.v ====
// Notes on behaviour
// - Sample all eleven strap pins while reset is active to pick modes.
// - After reset the strap pins become LED outputs or push-button inputs.
// - Duplex strap: high full duplex, low half duplex; default full.
// - Link-type strap: high four-bit 10/100 link, low reduced gigabit link.
// - Auto-negotiation strap: high enables negotiation, low disables; default on.
// - Isolate strap: high isolates host interface in PHY role only, low leaves it active.
// - Speed field: 00 10M, 01 100M default, 10 1000M, 11 reserved.
// - Management address upper bits: 00, 08, 10 or 18 hex.
// - Role strap: high MAC role, low PHY role; MAC default.
// - Boot strap kept high; boot image always loads from module flash.
// - Internal reset comes from power-good, released about 215 ms later.
// - Accept zero-cross input in both roles; learn line frequency and phase.
// - Isolated PHY role puts host-interface outputs into high impedance.
// - Reduced gigabit link always runs full duplex regardless of duplex strap.
//
// The APB register port and the address map are this design's own decisions.
`timescale 1ns/100ps
`default_nettype none
`include "rscl_map.vh"

module rscl_top #(
    parameter integer RST_DELAY_CYC = `RSCL_RST_DELAY_CYC
) (
    // Clock, reset, enable
    input  wire        mclk,
    input  wire        rstn,
    input  wire        ce,
    // APB slave
    input  wire        psel,
    input  wire        penable,
    input  wire        pwrite,
    input  wire [7:0]  paddr,
    input  wire [31:0] pwdata,
    output reg  [31:0] prdata,
    output reg         pready,
    output reg         pslverr,
    // Power-good and open-drain reset line
    input  wire        power_good,
    input  wire        reset_line_in,
    output reg         reset_line_out,
    output reg         reset_line_oe_n,
    // Dual-purpose strap / LED / button pins
    input  wire [10:0] gpio_in,
    output reg  [10:0] gpio_out,
    output reg  [10:0] gpio_oe_n,
    // Zero-cross input
    input  wire        zero_cross_in,
    // Decoded configuration
    output reg         sys_rstn,
    output reg         host_role_mac,
    output reg         host_link_type_select,
    output reg         full_duplex,
    output reg         autoneg_en,
    output reg         host_if_hiz,
    output reg  [1:0]  speed_sel,
    output reg  [4:0]  mgmt_addr,
    output reg         boot_from_flash,
    output reg         strap_fault,
    output reg         zc_tick
);

    // ----------------------------------------------------------------
    // Declarations
    // ----------------------------------------------------------------
    reg         pg_s1_r;
    reg         pg_s2_r;
    reg         rline_s1_r;
    reg         rline_s2_r;
    reg  [10:0] gpio_s1_r;
    reg  [10:0] gpio_s2_r;
    reg         zc_s1_r;
    reg         zc_s2_r;
    reg         zc_s3_r;
    reg  [31:0] rst_cnt_r;
    reg         rst_done_r;
    reg         in_reset_r;
    reg  [10:0] strap_r;
    reg  [10:0] led_out_r;
    reg  [10:0] led_en_r;
    reg  [23:0] zc_cnt_r;
    reg  [23:0] zc_period_r;
    reg  [31:0] rd_data_nxt;
    reg         rd_hit_nxt;
    wire        in_reset_nxt;
    wire        zc_rise;
    wire        apb_setup;
    wire        apb_write;
    wire [1:0]  speed_nxt;
    wire [14:0] config_word;

    // ----------------------------------------------------------------
    // Helpers
    // ----------------------------------------------------------------
    // Widens an eleven-bit pin vector to a bus word
    function [31:0] pad_pins;
        input [10:0] pins;
        begin
            pad_pins = {21'h00_0000, pins};
        end
    endfunction

    // Widens a zero-cross count to a bus word
    function [31:0] pad_count;
        input [23:0] count;
        begin
            pad_count = {8'h00, count};
        end
    endfunction

    // Write strobe for one register offset
    function wr_hit;
        input       wr_now;
        input [7:0] addr;
        input [7:0] ofs;
        begin
            wr_hit = wr_now & (addr == ofs);
        end
    endfunction

    // ----------------------------------------------------------------
    // Input synchronisers
    // ----------------------------------------------------------------
    always @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            pg_s1_r    <= 1'b0;
            pg_s2_r    <= 1'b0;
            rline_s1_r <= 1'b0;
            rline_s2_r <= 1'b0;
            gpio_s1_r  <= `RSCL_STRAP_RESET;
            gpio_s2_r  <= `RSCL_STRAP_RESET;
            zc_s1_r    <= 1'b0;
            zc_s2_r    <= 1'b0;
            zc_s3_r    <= 1'b0;
        end else if (ce) begin
            pg_s1_r    <= power_good;
            pg_s2_r    <= pg_s1_r;
            rline_s1_r <= reset_line_in;
            rline_s2_r <= rline_s1_r;
            gpio_s1_r  <= gpio_in;
            gpio_s2_r  <= gpio_s1_r;
            zc_s1_r    <= zero_cross_in;
            zc_s2_r    <= zc_s1_r;
            zc_s3_r    <= zc_s2_r;
        end
    end

    // ----------------------------------------------------------------
    // Reset sequencer
    // ----------------------------------------------------------------
    // Delay counter restarts whenever power-good drops
    always @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            rst_cnt_r  <= 32'h0000_0000;
            rst_done_r <= 1'b0;
        end else if (ce) begin
            if (!pg_s2_r) begin
                rst_cnt_r  <= 32'h0000_0000;
                rst_done_r <= 1'b0;
            end else if (!rst_done_r) begin
                if (rst_cnt_r == RST_DELAY_CYC - 1) begin
                    rst_done_r <= 1'b1;
                end
                rst_cnt_r <= rst_cnt_r + 32'h0000_0001;
            end
        end
    end

    // External source holding the line low keeps reset active
    assign in_reset_nxt = ~rst_done_r | ~rline_s2_r;

    always @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            in_reset_r      <= 1'b1;
            sys_rstn        <= 1'b0;
            reset_line_out  <= 1'b0;
            reset_line_oe_n <= 1'b0;
        end else if (ce) begin
            in_reset_r      <= in_reset_nxt;
            sys_rstn        <= ~in_reset_nxt;
            reset_line_out  <= 1'b0;
            reset_line_oe_n <= rst_done_r;
        end
    end

    // ----------------------------------------------------------------
    // Strap capture
    // ----------------------------------------------------------------
    // Capture runs up to the edge at which the pins start to drive
    always @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            strap_r <= `RSCL_STRAP_RESET;
        end else if (ce) begin
            if (in_reset_r) begin
                strap_r <= gpio_s2_r;
            end
        end
    end

    // ----------------------------------------------------------------
    // Configuration decode
    // ----------------------------------------------------------------
    assign speed_nxt = {strap_r[`RSCL_S_SPEED1], strap_r[`RSCL_S_SPEED0]};

    always @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            host_role_mac         <= 1'b1;
            host_link_type_select <= 1'b1;
            full_duplex           <= 1'b1;
            autoneg_en            <= 1'b1;
            host_if_hiz           <= 1'b0;
            speed_sel             <= `RSCL_SPEED_100;
            mgmt_addr             <= 5'h08;
            boot_from_flash       <= 1'b1;
            strap_fault           <= 1'b0;
        end else if (ce) begin
            host_role_mac         <= strap_r[`RSCL_S_ROLE];
            host_link_type_select <= strap_r[`RSCL_S_LINK_TYPE];
            full_duplex           <= strap_r[`RSCL_S_DUPLEX] |
                                     ~strap_r[`RSCL_S_LINK_TYPE];
            autoneg_en            <= strap_r[`RSCL_S_AUTONEG];
            host_if_hiz           <= strap_r[`RSCL_S_ISOLATE] &
                                     ~strap_r[`RSCL_S_ROLE];
            speed_sel             <= speed_nxt;
            mgmt_addr             <= {strap_r[`RSCL_S_MGMT4],
                                      strap_r[`RSCL_S_MGMT3], 3'h0};
            boot_from_flash       <= 1'b1;
            strap_fault           <= ~strap_r[`RSCL_S_MEM_TYPE] |
                                     ~strap_r[`RSCL_S_BOOT_SRC];
        end
    end

    assign config_word = {strap_fault, boot_from_flash, mgmt_addr,
                          (speed_sel == `RSCL_SPEED_RSVD), speed_sel,
                          host_if_hiz, autoneg_en, full_duplex,
                          host_link_type_select, host_role_mac};

    // ----------------------------------------------------------------
    // LED and push-button pins
    // ----------------------------------------------------------------
    // Pins stay released during reset so the straps can be read
    always @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            gpio_out  <= 11'h000;
            gpio_oe_n <= 11'h7ff;
        end else if (ce) begin
            gpio_out  <= led_out_r;
            gpio_oe_n <= ~(led_en_r & {11{~in_reset_nxt}});
        end
    end

    // ----------------------------------------------------------------
    // Zero-cross timing
    // ----------------------------------------------------------------
    assign zc_rise = zc_s2_r & ~zc_s3_r;

    always @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            zc_cnt_r    <= 24'h00_0000;
            zc_period_r <= 24'h00_0000;
            zc_tick     <= 1'b0;
        end else if (ce) begin
            zc_tick <= zc_rise;
            if (zc_rise) begin
                zc_period_r <= zc_cnt_r;
                zc_cnt_r    <= 24'h00_0001;
            end else if (zc_cnt_r != 24'hff_ffff) begin
                zc_cnt_r <= zc_cnt_r + 24'h00_0001;
            end
        end
    end

    // ----------------------------------------------------------------
    // APB register access
    // ----------------------------------------------------------------
    // Reads decode at the setup edge so data stands in the access cycle
    assign apb_setup = psel & ~penable;
    assign apb_write = psel & penable & pready & pwrite;

    always @* begin
        rd_data_nxt = 32'h0000_0000;
        rd_hit_nxt  = 1'b1;
        case (paddr)
            `RSCL_OFS_STRAP: begin
                rd_data_nxt = pad_pins(strap_r);
            end
            `RSCL_OFS_CONFIG: begin
                rd_data_nxt = {17'h0_0000, config_word};
            end
            `RSCL_OFS_LED_OUT: begin
                rd_data_nxt = pad_pins(led_out_r);
            end
            `RSCL_OFS_LED_EN: begin
                rd_data_nxt = pad_pins(led_en_r);
            end
            `RSCL_OFS_STATUS: begin
                rd_data_nxt = {15'h0000, in_reset_r, 5'h00, gpio_s2_r};
            end
            `RSCL_OFS_ZC_PERIOD: begin
                rd_data_nxt = pad_count(zc_period_r);
            end
            `RSCL_OFS_ZC_PHASE: begin
                rd_data_nxt = pad_count(zc_cnt_r);
            end
            default: begin
                rd_hit_nxt = 1'b0;
            end
        endcase
    end

    always @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            prdata  <= 32'h0000_0000;
            pready  <= 1'b0;
            pslverr <= 1'b0;
        end else if (ce) begin
            pready <= apb_setup;
            if (apb_setup) begin
                prdata  <= pwrite ? 32'h0000_0000 : rd_data_nxt;
                pslverr <= ~rd_hit_nxt;
            end else if (!psel) begin
                prdata  <= 32'h0000_0000;
                pslverr <= 1'b0;
            end
        end
    end

    always @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            led_out_r <= 11'h000;
            led_en_r  <= 11'h000;
        end else if (ce) begin
            if (wr_hit(apb_write, paddr, `RSCL_OFS_LED_OUT)) begin
                led_out_r <= pwdata[10:0];
            end
            if (wr_hit(apb_write, paddr, `RSCL_OFS_LED_EN)) begin
                led_en_r <= pwdata[10:0];
            end
        end
    end

endmodule
`default_nettype wire
